//--- bidir_fifo_regs.svh
// constants for the port-b bidirectional fifo block
`ifndef BIDIR_FIFO_REGS_SVH
`define BIDIR_FIFO_REGS_SVH

`define FIFO_DATA_W 18
`define FIFO_DEPTH 32
`define OFFSET_DEFAULT 8
`define PIN_SYNC_STAGES 2

// port a resource codes on port_a_resource_select
`define RES_DATA 3'h0
`define RES_AE_AB 3'h1
`define RES_AF_AB 3'h2
`define RES_AE_BA 3'h3
`define RES_AF_BA 3'h4
`define RES_MODE 3'h5
`define MODE_BYPASS_BIT 0

`endif

//--- bidir_fifo_pkg.sv
// types shared by the bidirectional fifo block
`include "bidir_fifo_regs.svh"

package bidir_fifo_pkg;

	typedef struct packed {
		logic clock;
		logic transfer_enable_n;
		logic direction;
		logic output_enable_n;
		logic [`FIFO_DATA_W-1:0] bus;
	} port_b_pins_type;

	typedef struct packed {
		logic clock;
		logic transfer_enable_n;
		logic direction;
		logic select_n;
		logic output_enable_n;
		logic [2:0] resource_select;
		logic [`FIFO_DATA_W-1:0] bus;
	} port_a_pins_type;

	// flags that change on port b edges
	typedef struct packed {
		logic ab_empty_n;
		logic ab_almost_empty_n;
		logic ba_full_n;
		logic ba_almost_full_n;
		logic passthrough_n;
	} b_flags_type;

	// flags that change on port a edges
	typedef struct packed {
		logic ab_full_n;
		logic ab_almost_full_n;
		logic ba_empty_n;
		logic ba_almost_empty_n;
	} a_flags_type;

	typedef enum logic {msg_empty, msg_held} msg_state_type;

endpackage

//--- sync_pins.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none

module sync_pins #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta <= '0;
			q_out <= '0;
		end else begin
			meta <= d_in;
			q_out <= meta;
		end
	end

endmodule

`default_nettype wire

//--- fifo_store.sv
// single-clock fifo with registered read data and word count
`timescale 1ns/1ns
`default_nettype none

module fifo_store #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 32,
	localparam int AW = $clog2(DEPTH),
	localparam int CW = $clog2(DEPTH + 1)
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out,
	output logic [CW-1:0] level_out
);

	localparam logic [CW-1:0] FULL_LEVEL = CW'(DEPTH);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic push;
	logic pop;

	// refused transfers leave pointers and count alone
	assign in_ready_out = level_out != FULL_LEVEL;
	assign out_valid_out = level_out != '0;
	assign push = in_valid_in && in_ready_out;
	assign pop = out_ready_in && out_valid_out;

	function automatic logic [AW-1:0] step(input logic [AW-1:0] ptr);
		step = (ptr == LAST_PTR) ? '0 : ptr + 1'b1;
	endfunction

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			out_data_out <= '0;
		end else if (pop) begin
			out_data_out <= mem[rd_ptr];
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= step(wr_ptr);
			end
			if (pop) begin
				rd_ptr <= step(rd_ptr);
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			level_out <= '0;
		end else if (push && !pop) begin
			level_out <= level_out + 1'b1;
		end else if (pop && !push) begin
			level_out <= level_out - 1'b1;
		end
	end

endmodule

`default_nettype wire

//--- bidir_fifo_port_b.sv
// bidirectional fifo: port b side, port a resources, bypass path and flags
`timescale 1ns/1ns
`default_nettype none
`include "bidir_fifo_regs.svh"

module bidir_fifo_port_b import bidir_fifo_pkg::*; #(
	parameter int DATA_W = `FIFO_DATA_W,
	parameter int DEPTH = `FIFO_DEPTH,
	parameter int OFFSET_RESET = `OFFSET_DEFAULT
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic port_b_clock_in,
	input wire logic port_b_transfer_enable_n_in,
	input wire logic port_b_direction_in,
	input wire logic port_b_output_enable_n_in,
	input wire logic [DATA_W-1:0] port_b_bus_in,
	output logic [DATA_W-1:0] port_b_bus_out,
	output logic port_b_bus_oe_out,
	output logic ab_empty_n_out,
	output logic ab_almost_empty_n_out,
	output logic ba_full_n_out,
	output logic ba_almost_full_n_out,
	output logic port_b_passthrough_n_out,
	input wire logic port_a_clock_in,
	input wire logic port_a_transfer_enable_n_in,
	input wire logic port_a_direction_in,
	input wire logic port_a_select_n_in,
	input wire logic port_a_output_enable_n_in,
	input wire logic [2:0] port_a_resource_select_in,
	input wire logic [DATA_W-1:0] port_a_bus_in,
	output logic [DATA_W-1:0] port_a_bus_out,
	output logic port_a_bus_oe_out,
	output logic ab_full_n_out,
	output logic ab_almost_full_n_out,
	output logic ba_empty_n_out,
	output logic ba_almost_empty_n_out
);

	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	localparam logic [CW-1:0] OFFSET_C = CW'(OFFSET_RESET);

	port_b_pins_type b_raw;
	port_b_pins_type b_sync;
	port_a_pins_type a_raw;
	port_a_pins_type a_sync;
	b_flags_type b_flags;
	a_flags_type a_flags;
	logic b_clk_prev;
	logic a_clk_prev;
	logic b_rise;
	logic a_rise;
	logic b_upd;
	logic a_upd;
	logic b_wr;
	logic b_rd;
	logic a_wr;
	logic a_rd;
	logic a_data_sel;
	logic bypass;
	logic [CW-1:0] ae_ab;
	logic [CW-1:0] af_ab;
	logic [CW-1:0] ae_ba;
	logic [CW-1:0] af_ba;
	msg_state_type ab_state;
	msg_state_type ba_state;
	logic [DATA_W-1:0] ab_msg;
	logic [DATA_W-1:0] ba_msg;
	logic ab_push;
	logic ab_pop;
	logic ba_push;
	logic ba_pop;
	logic ab_in_ready;
	logic ba_in_ready;
	logic ab_out_valid;
	logic ba_out_valid;
	logic [DATA_W-1:0] ab_rdata;
	logic [DATA_W-1:0] ba_rdata;
	logic [CW-1:0] ab_level;
	logic [CW-1:0] ba_level;
	logic b_pop_d1;
	logic a_pop_d1;

	// every pin passes two flops; clock and data share the same delay
	assign b_raw = '{port_b_clock_in, port_b_transfer_enable_n_in, port_b_direction_in,
		port_b_output_enable_n_in, port_b_bus_in};
	assign a_raw = '{port_a_clock_in, port_a_transfer_enable_n_in, port_a_direction_in,
		port_a_select_n_in, port_a_output_enable_n_in, port_a_resource_select_in,
		port_a_bus_in};

	sync_pins #(.WIDTH($bits(port_b_pins_type))) b_pin_sync (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.d_in(b_raw),
		.q_out(b_sync)
	);

	sync_pins #(.WIDTH($bits(port_a_pins_type))) a_pin_sync (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.d_in(a_raw),
		.q_out(a_sync)
	);

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			b_clk_prev <= 1'b0;
			a_clk_prev <= 1'b0;
			b_upd <= 1'b0;
			a_upd <= 1'b0;
		end else begin
			b_clk_prev <= b_sync.clock;
			a_clk_prev <= a_sync.clock;
			// flags settle one cycle after the edge so they include its transfer
			b_upd <= b_rise;
			a_upd <= a_rise;
		end
	end

	assign b_rise = b_sync.clock && !b_clk_prev;
	assign a_rise = a_sync.clock && !a_clk_prev;
	assign b_wr = b_rise && !b_sync.transfer_enable_n && !b_sync.direction;
	assign b_rd = b_rise && !b_sync.transfer_enable_n && b_sync.direction;
	assign a_wr = a_rise && !a_sync.transfer_enable_n && !a_sync.select_n
		&& !a_sync.direction;
	assign a_rd = a_rise && !a_sync.transfer_enable_n && !a_sync.select_n
		&& a_sync.direction;
	assign a_data_sel = a_sync.resource_select == `RES_DATA;

	// queues are ignored in bypass mode; fifo refuses full writes and empty reads
	assign ab_push = a_wr && a_data_sel && !bypass;
	assign ab_pop = b_rd && !bypass && ab_out_valid;
	assign ba_push = b_wr && !bypass;
	assign ba_pop = a_rd && a_data_sel && !bypass && ba_out_valid;

	fifo_store #(.WIDTH(DATA_W), .DEPTH(DEPTH)) ab_queue (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.in_valid_in(ab_push),
		.in_ready_out(ab_in_ready),
		.in_data_in(a_sync.bus),
		.out_valid_out(ab_out_valid),
		.out_ready_in(ab_pop),
		.out_data_out(ab_rdata),
		.level_out(ab_level)
	);

	fifo_store #(.WIDTH(DATA_W), .DEPTH(DEPTH)) ba_queue (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.in_valid_in(ba_push),
		.in_ready_out(ba_in_ready),
		.in_data_in(b_sync.bus),
		.out_valid_out(ba_out_valid),
		.out_ready_in(ba_pop),
		.out_data_out(ba_rdata),
		.level_out(ba_level)
	);

	// port a programming of offsets and mode
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ae_ab <= OFFSET_C;
			af_ab <= OFFSET_C;
			ae_ba <= OFFSET_C;
			af_ba <= OFFSET_C;
			bypass <= 1'b0;
		end else if (a_wr) begin
			unique case (a_sync.resource_select)
				`RES_AE_AB: ae_ab <= a_sync.bus[CW-1:0];
				`RES_AF_AB: af_ab <= a_sync.bus[CW-1:0];
				`RES_AE_BA: ae_ba <= a_sync.bus[CW-1:0];
				`RES_AF_BA: af_ba <= a_sync.bus[CW-1:0];
				`RES_MODE: bypass <= a_sync.bus[`MODE_BYPASS_BIT];
				default: ;
			endcase
		end
	end

	// a-to-b bypass message: a loads, b takes; a write onto a held message is refused
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ab_state <= msg_empty;
			ab_msg <= '0;
		end else if (bypass && a_wr && a_data_sel && ab_state == msg_empty) begin
			ab_state <= msg_held;
			ab_msg <= a_sync.bus;
		end else if (bypass && b_rd && ab_state == msg_held) begin
			ab_state <= msg_empty;
		end
	end

	// b-to-a bypass message
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ba_state <= msg_empty;
			ba_msg <= '0;
		end else if (bypass && b_wr && ba_state == msg_empty) begin
			ba_state <= msg_held;
			ba_msg <= b_sync.bus;
		end else if (bypass && a_rd && a_data_sel && ba_state == msg_held) begin
			ba_state <= msg_empty;
		end
	end

	// port b read data; fifo data lands one cycle after the pop
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			port_b_bus_out <= '0;
			b_pop_d1 <= 1'b0;
		end else begin
			b_pop_d1 <= ab_pop;
			if (b_rd && bypass && ab_state == msg_held) begin
				port_b_bus_out <= ab_msg;
			end else if (b_pop_d1) begin
				port_b_bus_out <= ab_rdata;
			end
		end
	end

	// port a read data by resource
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			port_a_bus_out <= '0;
			a_pop_d1 <= 1'b0;
		end else begin
			a_pop_d1 <= ba_pop;
			if (a_pop_d1) begin
				port_a_bus_out <= ba_rdata;
			end else if (a_rd) begin
				unique case (a_sync.resource_select)
					`RES_DATA: begin
						if (bypass && ba_state == msg_held) begin
							port_a_bus_out <= ba_msg;
						end
					end
					`RES_AE_AB: port_a_bus_out <= DATA_W'(ae_ab);
					`RES_AF_AB: port_a_bus_out <= DATA_W'(af_ab);
					`RES_AE_BA: port_a_bus_out <= DATA_W'(ae_ba);
					`RES_AF_BA: port_a_bus_out <= DATA_W'(af_ba);
					`RES_MODE: port_a_bus_out <= DATA_W'(bypass);
					default: ;
				endcase
			end
		end
	end

	// bus drivers follow the synchronised controls, not the port clock
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			port_b_bus_oe_out <= 1'b0;
			port_a_bus_oe_out <= 1'b0;
		end else begin
			port_b_bus_oe_out <= b_sync.direction && !b_sync.output_enable_n;
			port_a_bus_oe_out <= a_sync.direction && !a_sync.output_enable_n
				&& !a_sync.select_n;
		end
	end

	// port b flags: only on port b edges
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			b_flags <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
		end else if (b_upd) begin
			b_flags.ab_empty_n <= bypass ? ab_state == msg_held : ab_out_valid;
			b_flags.ab_almost_empty_n <= ab_level > ae_ab;
			b_flags.ba_full_n <= bypass ? ba_state == msg_empty : ba_in_ready;
			// a wrapping difference for offsets above depth is the user's lookout
			b_flags.ba_almost_full_n <= !(ba_level > DEPTH_C - af_ba);
			b_flags.passthrough_n <= !bypass;
		end
	end

	// port a flags: only on port a edges
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			a_flags <= '{1'b1, 1'b1, 1'b0, 1'b0};
		end else if (a_upd) begin
			a_flags.ab_full_n <= bypass ? ab_state == msg_empty : ab_in_ready;
			a_flags.ab_almost_full_n <= !(ab_level > DEPTH_C - af_ab);
			a_flags.ba_empty_n <= bypass ? ba_state == msg_held : ba_out_valid;
			a_flags.ba_almost_empty_n <= ba_level > ae_ba;
		end
	end

	assign ab_empty_n_out = b_flags.ab_empty_n;
	assign ab_almost_empty_n_out = b_flags.ab_almost_empty_n;
	assign ba_full_n_out = b_flags.ba_full_n;
	assign ba_almost_full_n_out = b_flags.ba_almost_full_n;
	assign port_b_passthrough_n_out = b_flags.passthrough_n;
	assign ab_full_n_out = a_flags.ab_full_n;
	assign ab_almost_full_n_out = a_flags.ab_almost_full_n;
	assign ba_empty_n_out = a_flags.ba_empty_n;
	assign ba_almost_empty_n_out = a_flags.ba_almost_empty_n;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	b_write_queue_a: assert property (b_wr && !bypass && ba_in_ready && !ba_pop
		|=> ba_level == $past(ba_level) + 1) else $error("port b write not stored");
	bypass_b_msg_a: assert property (b_wr && bypass && ba_state == msg_empty
		|=> ba_state == msg_held && ba_msg == $past(b_sync.bus))
		else $error("bypass message not captured");
	b_idle_edge_a: assert property (!b_wr && !ba_pop |=> $stable(ba_level))
		else $error("b-to-a count moved without transfer");
	b_float_bus_a: assert property (b_sync.output_enable_n |=> !port_b_bus_oe_out)
		else $error("port b bus driven while disabled");
	ab_empty_flag_a: assert property (b_upd && !bypass
		|=> ab_empty_n_out == ($past(ab_level) != 0)) else $error("empty flag wrong");
	ab_almost_empty_a: assert property (b_upd
		|=> ab_almost_empty_n_out == ($past(ab_level) > $past(ae_ab)))
		else $error("almost-empty flag wrong");
	ab_full_flag_a: assert property (a_upd && !bypass
		|=> ab_full_n_out == ($past(ab_level) != DEPTH)) else $error("full flag wrong");
	bypass_full_flag_a: assert property (a_upd && bypass
		|=> ab_full_n_out == ($past(ab_state) == msg_empty))
		else $error("bypass full flag wrong");
	full_refusal_a: assert property (ba_level == DEPTH && ba_push && !ba_pop
		|=> ba_level == DEPTH) else $error("write while full changed count");
	passthrough_flag_a: assert property (b_upd
		|=> port_b_passthrough_n_out == !$past(bypass)) else $error("passthrough flag wrong");
	b_flags_hold_a: assert property (!b_upd |=> $stable(b_flags))
		else $error("port b flag moved off its edge");

endmodule

`default_nettype wire

//--- port_host.sv
// host-side model of one port: strobes the port clock around each transfer
`timescale 1ns/1ns
`default_nettype none
`include "bidir_fifo_regs.svh"

module port_host (
	input wire logic clk_in,
	output logic clock_out,
	output logic en_n_out,
	output logic dir_out,
	output logic oe_n_out,
	output logic sel_n_out,
	output logic [2:0] res_out,
	output logic [`FIFO_DATA_W-1:0] bus_out
);
	initial begin
		clock_out = 1'b0;
		en_n_out = 1'b1;
		dir_out = 1'b1;
		oe_n_out = 1'b0;
		sel_n_out = 1'b1;
		res_out = 3'h0;
		bus_out = 18'h0;
	end

	// four system cycles per phase keeps pins steady past the pin synchronisers
	task automatic xfer(input logic [2:0] res, input logic dir, input logic en_n,
			input logic oe_n, input logic [`FIFO_DATA_W-1:0] data);
		@(negedge clk_in);
		res_out = res;
		dir_out = dir;
		oe_n_out = oe_n;
		en_n_out = en_n;
		sel_n_out = 1'b0;
		// not driving: show the inverse so a stale value never passes
		bus_out = dir ? ~bus_out : data;
		repeat (4) @(negedge clk_in);
		clock_out = 1'b1;
		repeat (4) @(negedge clk_in);
		clock_out = 1'b0;
		repeat (4) @(negedge clk_in);
		en_n_out = 1'b1;
		sel_n_out = 1'b1;
		bus_out = ~bus_out;
	endtask
endmodule
`default_nettype wire

//--- bidir_fifo_port_b_tb_top.sv
// self-checking bench for the port-b fifo block with two host models
`timescale 1ns/1ns
`default_nettype none

module bidir_fifo_port_b_tb_top;
	import bidir_fifo_pkg::*;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	int n_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	logic a_clk, a_en_n, a_dir, a_oe_n, a_sel_n, a_oe, b_clk, b_en_n, b_dir, b_oe_n, b_oe;
	logic [2:0] a_res;
	logic [17:0] a_host, b_host, a_out, b_out, a_wire, b_wire;
	// flag bits in struct order; plain nets so each bit has its own driver
	wire [4:0] bf;
	wire [3:0] af;
	assign a_wire = a_oe ? a_out : a_host;
	assign b_wire = b_oe ? b_out : b_host;

	initial begin
		forever #25 clk_in = ~clk_in;
	end

	port_host host_a_u (.clk_in(clk_in), .clock_out(a_clk), .en_n_out(a_en_n), .dir_out(a_dir),
		.oe_n_out(a_oe_n), .sel_n_out(a_sel_n), .res_out(a_res), .bus_out(a_host));
	port_host host_b_u (.clk_in(clk_in), .clock_out(b_clk), .en_n_out(b_en_n), .dir_out(b_dir),
		.oe_n_out(b_oe_n), .sel_n_out(), .res_out(), .bus_out(b_host));

	bidir_fifo_port_b dut_u (.clk_in(clk_in), .resetn_in(resetn_in),
		.port_b_clock_in(b_clk), .port_b_transfer_enable_n_in(b_en_n),
		.port_b_direction_in(b_dir), .port_b_output_enable_n_in(b_oe_n),
		.port_b_bus_in(b_wire), .port_b_bus_out(b_out), .port_b_bus_oe_out(b_oe),
		.ab_empty_n_out(bf[4]), .ab_almost_empty_n_out(bf[3]),
		.ba_full_n_out(bf[2]), .ba_almost_full_n_out(bf[1]),
		.port_b_passthrough_n_out(bf[0]), .port_a_clock_in(a_clk),
		.port_a_transfer_enable_n_in(a_en_n), .port_a_direction_in(a_dir),
		.port_a_select_n_in(a_sel_n), .port_a_output_enable_n_in(a_oe_n),
		.port_a_resource_select_in(a_res), .port_a_bus_in(a_wire),
		.port_a_bus_out(a_out), .port_a_bus_oe_out(a_oe), .ab_full_n_out(af[3]),
		.ab_almost_full_n_out(af[2]), .ba_empty_n_out(af[1]),
		.ba_almost_empty_n_out(af[0]));

	task automatic give_verdict();
		if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask

	task automatic pa(input logic [2:0] r, input logic d, input logic e, input logic [17:0] v);
		host_a_u.xfer(r, d, e, 1'b0, v);
	endtask

	task automatic pb(input logic d, input logic e, input logic o, input logic [17:0] v);
		host_b_u.xfer(3'h0, d, e, o, v);
	endtask

	task automatic do_reset();
		resetn_in = 1'b0;
		repeat (12) @(negedge clk_in);
		resetn_in = 1'b1;
		repeat (4) @(negedge clk_in);
	endtask

	// ceiling well above the roughly 1700 cycles the sequence needs
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 10000) begin
			n_errors++;
			give_verdict();
		end
	end

	initial begin
		int cnt;
		do_reset();
		chk(bf, 5'h07);
		chk(af, 4'hc);
		pb(1'b1, 1'b0, 1'b0, 18'h0);
		chk(b_out, 18'h0);
		chk(bf, 5'h07);
		for (int i = 1; i <= 33; i++) begin
			pa(3'h0, 1'b0, 1'b0, 18'(i));
			cnt = (i > 32) ? 32 : i;
			chk(af[3:2], {cnt < 32, cnt <= 24});
			if (i == 8 || i == 9) begin
				pb(1'b1, 1'b1, 1'b0, 18'h0);
				chk(b_out, 18'h0);
				chk(bf[4:3], {1'b1, i > 8});
			end
		end
		for (int i = 1; i <= 32; i++) begin
			pb(1'b1, 1'b0, 1'b0, 18'h0);
			chk(b_out, 18'(i));
			chk(b_oe, 1'b1);
		end
		chk(bf[4], 1'b0);
		pb(1'b1, 1'b0, 1'b1, 18'h0);
		chk(b_out, 18'h20);
		chk(b_oe, 1'b0);
		// af offset of 30 puts the threshold at two words
		pa(3'h4, 1'b0, 1'b0, 18'h1e);
		for (int i = 1; i <= 3; i++) begin
			pb(1'b0, 1'b0, 1'b0, 18'h200 + 18'(i));
			chk(bf[2:1], {1'b1, i <= 2});
		end
		pa(3'h0, 1'b1, 1'b1, 18'h0);
		chk(af[1:0], 2'h2);
		for (int i = 1; i <= 3; i++) begin
			pa(3'h0, 1'b1, 1'b0, 18'h0);
			chk(a_out, 18'h200 + 18'(i));
			chk(a_oe, 1'b1);
		end
		chk(af[1], 1'b0);
		pa(3'h4, 1'b1, 1'b0, 18'h0);
		chk(a_out, 18'h1e);
		pa(3'h5, 1'b0, 1'b0, 18'h1);
		pb(1'b1, 1'b1, 1'b0, 18'h0);
		chk(bf[0], 1'b0);
		pa(3'h0, 1'b0, 1'b0, 18'h155);
		chk(af[3], 1'b0);
		pb(1'b1, 1'b1, 1'b0, 18'h0);
		chk(bf[4], 1'b1);
		pb(1'b1, 1'b0, 1'b0, 18'h0);
		chk(b_out, 18'h155);
		chk(bf[4], 1'b0);
		pa(3'h0, 1'b1, 1'b1, 18'h0);
		chk(af[3], 1'b1);
		pb(1'b0, 1'b0, 1'b0, 18'h2aa);
		chk(bf[2], 1'b0);
		pa(3'h0, 1'b1, 1'b1, 18'h0);
		chk(af[1], 1'b1);
		pa(3'h0, 1'b1, 1'b0, 18'h0);
		chk(a_out, 18'h2aa);
		pa(3'h0, 1'b1, 1'b1, 18'h0);
		chk(af[1], 1'b0);
		pb(1'b1, 1'b1, 1'b0, 18'h0);
		chk(bf[2], 1'b1);
		// port a still reads with output enable low but is deselected
		chk(a_oe, 1'b0);
		// leave bypass and write b-to-a past full; af offset is still 30
		pa(3'h5, 1'b0, 1'b0, 18'h0);
		for (int i = 1; i <= 33; i++) begin
			pb(1'b0, 1'b0, 1'b0, 18'h300 + 18'(i));
			cnt = (i > 32) ? 32 : i;
			chk(bf[2:1], {cnt < 32, cnt <= 2});
		end
		chk(bf[0], 1'b1);
		do_reset();
		chk(bf, 5'h07);
		chk(af, 4'hc);
		pa(3'h4, 1'b1, 1'b0, 18'h0);
		chk(a_out, 18'h8);
		for (int r = 1; r <= 3; r++) begin
			pa(3'(r), 1'b0, 1'b0, 18'(r + 2));
			pa(3'(r), 1'b1, 1'b0, 18'h0);
			chk(a_out, 18'(r + 2));
		end
		give_verdict();
	end
endmodule
`default_nettype wire
